// ### core/bds_pkg.sv
/*
  bds_pkg: constants and types for the transistor drive phase sequencer.
  Assumes a 125 MHz core clock; analog levels arrive as digitised codes.
*/
package bds_pkg;

  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned CTRL_W          = 8;
  localparam int unsigned CNT_W           = 16;
  // force-on pulse length
  localparam int unsigned FON_NS          = 200;
  localparam int unsigned FON_CYC         = (FON_NS * CLK_MHZ) / 1000;
  // probe pulse length
  localparam int unsigned PROBE_NS        = 2000;
  localparam int unsigned PROBE_CYC       = (PROBE_NS * CLK_MHZ) / 1000;
  // target from base pull-low until collector has risen about 30 V
  localparam int unsigned TURNOFF_NS      = 100;
  localparam int unsigned TURNOFF_CYC     = (TURNOFF_NS * CLK_MHZ) / 1000;
  // adaptive phase length limits and trim step
  localparam logic [CNT_W-1:0] ADAPT_MIN  = 16'h0004;
  localparam logic [CNT_W-1:0] ADAPT_MAX  = 16'h0400;
  localparam logic [CNT_W-1:0] ADAPT_RST  = 16'h0040;
  localparam logic [CNT_W-1:0] ADAPT_STEP = 16'h0001;
  // switching frequency: ceiling at 70 % of full control code
  localparam int unsigned FMAX_HZ         = 65_000;
  localparam int unsigned FMAX_PCT        = 70;
  localparam int unsigned PER_MIN_CYC     = CLK_HZ / FMAX_HZ;
  localparam logic [CNT_W-1:0] PER_MIN    = CNT_W'(PER_MIN_CYC);
  localparam logic [CTRL_W-1:0] CTRL_KNEE = CTRL_W'((255 * FMAX_PCT) / 100);
  // extra period cycles per control code below the knee
  localparam logic [CNT_W-1:0] PER_SLOPE  = 16'h00c8;
  localparam logic [CNT_W-1:0] TURNOFF_T  = CNT_W'(TURNOFF_CYC);
  localparam logic [CNT_W-1:0] FON_T      = CNT_W'(FON_CYC);
  localparam logic [CNT_W-1:0] PROBE_T    = CNT_W'(PROBE_CYC);

  typedef enum logic [1:0] {
    BDS_SLEEP,
    BDS_PROBE,
    BDS_JUDGE,
    BDS_RUN
  } bds_mode_t;

  typedef enum logic [2:0] {
    BDS_IDLE,
    BDS_FORCE_ON,
    BDS_ADAPT,
    BDS_STORE,
    BDS_TURN_OFF
  } bds_phase_t;

endpackage : bds_pkg

// ### core/bds_sync.sv
/*
  bds_sync: two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module bds_sync
  import bds_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);

  logic meta;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : bds_sync

// ### core/bds_sequencer.sv
/*
  bds_sequencer: drive phase sequencer for an external bipolar switch.
  Assumes comparators and supply threshold detectors are outside, as
  asynchronous levels; control voltage arrives as a settled digital code.
  Base drive output is a three-signal pin: source, pull-down, enable.
*/
`timescale 1ns/1ps
module bds_sequencer
  import bds_pkg::*;
#(
  parameter bit HAS_SUPP_DRIVE   = 1'b1,
  parameter bit HAS_START_ASSIST = 1'b1
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [CTRL_W-1:0] ctrl_code,
  input  wire logic              vcc_above_run,
  input  wire logic              vcc_above_sleep,
  input  wire logic              vcc_below_6v,
  input  wire logic              fb_above_start,
  input  wire logic              cs_trip_ctrl,
  input  wire logic              cs_trip_oc,
  input  wire logic              collector_rise_30v,
  output logic                   base_drive_src,
  output logic                   base_drive_sink,
  output logic                   base_drive_oe,
  output logic [CTRL_W-1:0]      base_drive_level,
  output logic                   emitter_drive_out,
  output logic                   supplementary_drive_out,
  output logic [CTRL_W-1:0]      peak_trip_level,
  output logic                   run_mode
);

  bds_mode_t        mode;
  bds_mode_t        next_mode;
  bds_phase_t       phase;
  bds_phase_t       next_phase;
  logic [CNT_W-1:0] ph_cnt;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] adapt_len;
  logic [CNT_W-1:0] off_cnt;
  logic             off_meas;
  logic             probe;

  logic s_run;
  logic s_sleep;
  logic s_low6;
  logic s_fb;
  logic s_tc;
  logic s_toc;
  logic s_rise;

  bds_sync u_sy_run  (.clk(clk), .rst(rst), .d(vcc_above_run),
                      .q(s_run));
  bds_sync u_sy_slp  (.clk(clk), .rst(rst), .d(vcc_above_sleep),
                      .q(s_sleep));
  bds_sync u_sy_l6   (.clk(clk), .rst(rst), .d(vcc_below_6v),
                      .q(s_low6));
  bds_sync u_sy_fb   (.clk(clk), .rst(rst), .d(fb_above_start),
                      .q(s_fb));
  bds_sync u_sy_tc   (.clk(clk), .rst(rst), .d(cs_trip_ctrl),
                      .q(s_tc));
  bds_sync u_sy_toc  (.clk(clk), .rst(rst), .d(cs_trip_oc),
                      .q(s_toc));
  bds_sync u_sy_rise (.clk(clk), .rst(rst), .d(collector_rise_30v),
                      .q(s_rise));

  // period shrinks as control rises, flat above the knee
  wire [CTRL_W-1:0] below_knee = (ctrl_code < CTRL_KNEE) ?
                                 CTRL_W'(CTRL_KNEE - ctrl_code) : '0;
  wire [CNT_W-1:0]  period     = CNT_W'(PER_MIN +
                                 CNT_W'(below_knee * PER_SLOPE));
  wire              trip       = s_tc | s_toc;
  wire              sleep_now  = ~s_sleep;
  // counters restart at zero on a phase's first cycle, so a phase of
  // n cycles is done when the count reaches n - 1
  wire [CNT_W-1:0]  ph_len     = (phase == BDS_FORCE_ON) ? FON_T :
                                 (probe ? PROBE_T : adapt_len);
  wire              ph_done    = (ph_cnt >= ph_len - 1'b1);
  wire [CNT_W-1:0]  per_last   = period - 1'b1;
  wire              start_cyc  = (phase == BDS_IDLE) &&
                                 ((mode == BDS_RUN && per_cnt >= per_last) ||
                                  (mode == BDS_SLEEP && s_run));
  wire              assist     = HAS_START_ASSIST && s_low6;

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      BDS_SLEEP: if (s_run) next_mode = BDS_PROBE;
      BDS_PROBE: if (phase == BDS_TURN_OFF) next_mode = BDS_JUDGE;
      BDS_JUDGE: if (s_fb) next_mode = BDS_RUN;
      BDS_RUN:   next_mode = BDS_RUN;
    endcase
    if (sleep_now)
      next_mode = BDS_SLEEP;
  end

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      BDS_IDLE:     if (start_cyc) next_phase = BDS_FORCE_ON;
      BDS_FORCE_ON: if (ph_done) next_phase = BDS_ADAPT;
      BDS_ADAPT:    if (ph_done) next_phase = BDS_STORE;
      BDS_STORE:    if (trip || probe) next_phase = BDS_TURN_OFF;
      BDS_TURN_OFF: next_phase = BDS_IDLE;
      default:      next_phase = BDS_IDLE;
    endcase
    if (sleep_now)
      next_phase = BDS_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode  <= BDS_SLEEP;
      phase <= BDS_IDLE;
    end
    else
    begin
      mode  <= next_mode;
      phase <= next_phase;
    end
  end

  // probe flag marks the single pulse issued on wake
  always_ff @(posedge clk)
  begin
    if (rst)
      probe <= 1'b0;
    else if (mode == BDS_SLEEP && s_run && !sleep_now)
      probe <= 1'b1;
    else if (phase == BDS_TURN_OFF || sleep_now)
      probe <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst || phase != next_phase)
      ph_cnt <= '0;
    else if (ph_cnt != '1)
      ph_cnt <= ph_cnt + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst || start_cyc)
      per_cnt <= '0;
    else if (per_cnt != '1)
      per_cnt <= per_cnt + 1'b1;
  end

  // measure pull-low to 30 V rise, then trim next adaptive length;
  // a late rise means too much stored charge, so shorten
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      off_meas  <= 1'b0;
      off_cnt   <= '0;
      adapt_len <= ADAPT_RST;
    end
    else if (phase == BDS_TURN_OFF)
    begin
      off_meas <= 1'b1;
      off_cnt  <= '0;
    end
    else if (off_meas)
    begin
      off_cnt <= off_cnt + 1'b1;
      if (s_rise || off_cnt == ADAPT_MAX)
      begin
        off_meas <= 1'b0;
        if (off_cnt > TURNOFF_T && adapt_len > ADAPT_MIN)
          adapt_len <= adapt_len - ADAPT_STEP;
        else if (off_cnt < TURNOFF_T && adapt_len < ADAPT_MAX)
          adapt_len <= adapt_len + ADAPT_STEP;
      end
    end
  end

  wire n_src  = (next_phase == BDS_FORCE_ON) ||
                (next_phase == BDS_ADAPT);
  wire n_oe   = (next_phase != BDS_STORE);
  wire n_sink = n_oe && !n_src;
  wire n_supp = HAS_SUPP_DRIVE && (next_phase == BDS_ADAPT);
  // emitter grounded from force-on to turn-off, released during storage under start assist; idle keeps it on too
  wire n_emit = !(next_phase == BDS_TURN_OFF) &&
                !(assist && next_phase == BDS_STORE);
  wire [CTRL_W-1:0] n_level = (next_phase == BDS_FORCE_ON) ? '1 :
                              (next_phase == BDS_ADAPT) ? ctrl_code : '0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      base_drive_src          <= 1'b0;
      base_drive_sink         <= 1'b1;
      base_drive_oe           <= 1'b1;
      base_drive_level        <= '0;
      emitter_drive_out       <= 1'b1;
      supplementary_drive_out <= 1'b0;
      peak_trip_level         <= '0;
      run_mode                <= 1'b0;
    end
    else
    begin
      base_drive_src          <= n_src;
      base_drive_sink         <= n_sink;
      base_drive_oe           <= n_oe;
      base_drive_level        <= n_level;
      emitter_drive_out       <= n_emit;
      supplementary_drive_out <= n_supp;
      peak_trip_level         <= ctrl_code;
      run_mode                <= (next_mode == BDS_RUN);
    end
  end

endmodule : bds_sequencer

// ### sim/bds_checker.sv
/* bds_checker: port properties of the drive phase sequencer.
   Bound to bds_sequencer from the bench top; one clock domain. */
`timescale 1ns/1ps
module bds_checker
  import bds_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [CTRL_W-1:0] ctrl_code,
  input wire logic              vcc_above_sleep,
  input wire logic              vcc_below_6v,
  input wire logic              cs_trip_ctrl,
  input wire logic              base_drive_src,
  input wire logic              base_drive_sink,
  input wire logic              base_drive_oe,
  input wire logic [CTRL_W-1:0] base_drive_level,
  input wire logic              emitter_drive_out,
  input wire logic              supplementary_drive_out,
  input wire logic [CTRL_W-1:0] peak_trip_level
);
  wire src  = base_drive_src;
  wire snk  = base_drive_sink;
  wire oe   = base_drive_oe;
  wire emit = emitter_drive_out;
  wire supp = supplementary_drive_out;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // turn-off lasts one cycle, then the emitter is grounded again
  sequence s_off;
    oe && snk && !emit ##1 emit;
  endsequence
  a_no_fight: assert property (!(src && snk))
    else $error("base source and sink both on");
  a_force_on: assert property ($rose(src) |->
    (base_drive_level == 8'hff)[*8] ##17 !supp ##1 supp)
    else $error("force-on pulse length wrong");
  a_supp_adapt: assert property (supp |-> src && oe)
    else $error("supplementary path joined outside adaptive drive");
  a_store_float: assert property (!oe |-> !src && !snk && !supp)
    else $error("base pin driven during storage");
  a_turn_off: assert property ($rose(oe) |-> s_off)
    else $error("turn-off step wrong");
  a_trip_off: assert property (
    !oe && cs_trip_ctrl |-> ##[1:4] snk)
    else $error("storage not ended after trip");
  a_sleep_stop: assert property (
    !vcc_above_sleep |-> ##[1:4] snk && !src)
    else $error("switching continued below sleep level");
  a_peak_track: assert property (!$past(rst) |->
    peak_trip_level == $past(ctrl_code))
    else $error("peak trip level does not follow control");
  a_emit_norm: assert property (!oe && !vcc_below_6v &&
    !$past(vcc_below_6v, 4) |-> emit)
    else $error("emitter released during storage above 6 V");
  a_emit_assist: assert property (!oe && vcc_below_6v &&
    $past(vcc_below_6v, 4) |-> !emit)
    else $error("emitter held during storage below 6 V");
endmodule : bds_checker

// ### sim/bds_partner.sv
/* bds_partner: behavioural switching transistor and transformer.
   Delays count clk cycles; the bench picks prompt or slow collector rise. */
`timescale 1ns/1ps
module bds_partner
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       base_drive_src,
  input  wire logic       base_drive_oe,
  input  wire logic [7:0] rise_dly,
  output logic            cs_trip_ctrl,
  output logic            collector_rise_30v
);
  localparam logic [7:0] STORE_DLY = 8'h14;
  logic [7:0] n_st;
  logic [7:0] n_off;
  // current ramps only while the base floats; trip holds till next turn-on
  always_ff @(posedge clk)
  begin
    if (rst || base_drive_src)
    begin
      n_st <= 8'h00;
      n_off <= 8'h00;
      cs_trip_ctrl <= 1'b0;
      collector_rise_30v <= 1'b0;
    end
    else
    begin
      if (!base_drive_oe)
        n_st <= n_st + 8'h01;
      if (n_st == STORE_DLY)
        cs_trip_ctrl <= 1'b1;
      if (cs_trip_ctrl && n_off != 8'hff)
        n_off <= n_off + 8'h01;
      if (cs_trip_ctrl && n_off == rise_dly)
        collector_rise_30v <= 1'b1;
    end
  end
endmodule : bds_partner

// ### sim/tb.sv
/* tb: directed scenarios for bds_sequencer against a transistor model.
   Assumes bds_partner and the bound bds_checker are compiled alongside. */
`timescale 1ns/1ps
module tb
  import bds_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, vcc_above_run = 1'b0, fb_above_start = 1'b0;
  logic vcc_above_sleep = 1'b1, vcc_below_6v = 1'b1, cs_trip_oc = 1'b0;
  logic cs_trip_ctrl, collector_rise_30v, run_mode, src_q = 1'b0;
  logic base_drive_src, base_drive_sink, base_drive_oe;
  logic emitter_drive_out, supplementary_drive_out;
  logic [CTRL_W-1:0] ctrl_code = 8'hff, base_drive_level, peak_trip_level;
  logic [7:0]  rise_dly = 8'h04;
  logic [31:0] errors = 0, num_checks = 0, cyc = 0, starts = 0, t0 = 0;
  logic [31:0] per = 0, an = 0, alen = 0;
  bds_sequencer i_dut (.clk, .rst, .ctrl_code, .vcc_above_run,
    .vcc_above_sleep, .vcc_below_6v, .fb_above_start, .cs_trip_ctrl,
    .cs_trip_oc, .collector_rise_30v, .base_drive_src, .base_drive_sink,
    .base_drive_oe, .base_drive_level, .emitter_drive_out,
    .supplementary_drive_out, .peak_trip_level, .run_mode);
  bds_partner i_far (.clk, .rst, .base_drive_src, .base_drive_oe, .rise_dly,
    .cs_trip_ctrl, .collector_rise_30v);
  initial forever #4 clk = ~clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks != 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_start;
    logic [31:0] s;
    s = starts;
    while (starts == s) tick(1);
  endtask : wait_start
  // period from start to start, adaptive length of the last cycle
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    src_q <= base_drive_src;
    if (base_drive_src && !src_q)
    begin
      starts <= starts + 1;
      per <= cyc - t0;
      t0 <= cyc;
    end
    an <= supplementary_drive_out ? an + 1 : 0;
    if (!supplementary_drive_out && an != 0)
      alen <= an;
    if (cyc == 32'h0000_9c40)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic probe_fail;
    vcc_above_run = 1'b1;
    tick(3000);
    chk("probe_len", alen, 32'(PROBE_T));
    chk("starts", starts, 32'h1);
    chk("run_mode", 32'(run_mode), 32'h0);
    vcc_above_sleep = 1'b0;
    vcc_above_run = 1'b0;
    tick(10);
    vcc_above_sleep = 1'b1;
    vcc_below_6v = 1'b0;
    fb_above_start = 1'b1;
    $display("done probe_fail");
  endtask : probe_fail
  task automatic probe_ok;
    vcc_above_run = 1'b1;
    while (starts < 32'h3) tick(1);
    chk("run_mode", 32'(run_mode), 32'h1);
    $display("done probe_ok");
  endtask : probe_ok
  task automatic freq_trim;
    logic [7:0]  cv [3] = '{8'hff, 8'hb2, 8'hb1};
    logic [7:0]  rd [3] = '{8'h04, 8'h3c, 8'h04};
    logic [31:0] dx [3] = '{32'h1, 32'hffff_ffff, 32'h1};
    logic [31:0] p [3];
    logic [31:0] a1;
    for (int i = 0; i < 3; i++)
    begin
      ctrl_code = cv[i];
      rise_dly = rd[i];
      wait_start();
      a1 = alen;
      wait_start();
      p[i] = per;
      chk("trim_step", alen - a1, dx[i]);
    end
    chk("period_ceiling", p[0], p[1]);
    chk("period_min", p[0], 32'(PER_MIN));
    chk("period_slope", p[2] - p[1], 32'(PER_SLOPE));
    $display("done freq_trim");
  endtask : freq_trim
  // over-current trip alone must end storage long before the model's trip
  task automatic oc_trip;
    while (base_drive_oe !== 1'b0) tick(1);
    cs_trip_oc = 1'b1;
    tick(3);
    chk("oc_off", 32'(base_drive_sink && base_drive_oe), 32'h1);
    chk("emit_release", 32'(emitter_drive_out), 32'h0);
    tick(1);
    chk("emit_ground", 32'(emitter_drive_out), 32'h1);
    chk("peak_level", 32'(peak_trip_level), 32'(ctrl_code));
    cs_trip_oc = 1'b0;
    $display("done oc_trip");
  endtask : oc_trip
  task automatic sleep_abort;
    while (supplementary_drive_out !== 1'b1) tick(1);
    chk("adapt_level", 32'(base_drive_level), 32'(ctrl_code));
    vcc_above_sleep = 1'b0;
    tick(4);
    chk("src_off", 32'(base_drive_src), 32'h0);
    chk("sink_on", 32'(base_drive_sink), 32'h1);
    tick(20);
    chk("run_mode", 32'(run_mode), 32'h0);
    $display("done sleep_abort");
  endtask : sleep_abort
  initial
  begin
    tick(8);
    rst = 1'b0;
    probe_fail();
    probe_ok();
    freq_trim();
    oc_trip();
    sleep_abort();
    wrap_up();
  end
endmodule : tb
bind bds_sequencer bds_checker i_chk (.clk, .rst, .ctrl_code,
  .vcc_above_sleep, .vcc_below_6v, .cs_trip_ctrl, .base_drive_src,
  .base_drive_sink, .base_drive_oe, .base_drive_level, .emitter_drive_out,
  .supplementary_drive_out, .peak_trip_level);
